// file: hw/mwbd_top.sv
// Purpose: config registers and memory claim for two base windows
// Assumes: config cycles already decoded to bus 0, device 0, function 0
// Notes:   both claims are reported if software overlaps the windows
//
// Function
// - capability pointer reads fixed E0h, read-only
// - egress base field holds address bits 35:12
// - egress bits 63:36 reserved, read zero
// - egress window disabled after reset until enabled
// - egress enable gates claiming of its window
// - egress window has no memory behind it
// - register window base holds bits 35:14
// - register window register resets to all zeros
// - register window enable gates its claiming
// - register window has no memory behind it
// - status reports capability list present, hardwired
`timescale 1ns/100ps
`default_nettype none
module mwbd_top
	import mwbd_pkg::*;
(
	input  wire logic          clk,
	input  wire logic          arst_n,
	input  wire mwbd_cfg_req_s cfg_req,
	output mwbd_cfg_rsp_s      cfg_rsp,
	input  wire mwbd_mem_req_s mem_req,
	output mwbd_claim_s        claim
);
	logic [63:0]   egr_q;      // egress window register
	logic [63:0]   egr_d;
	logic [63:0]   reg_q;      // register window register
	logic [63:0]   reg_d;
	mwbd_cfg_rsp_s rsp_q;      // registered config answer
	mwbd_cfg_rsp_s rsp_d;
	mwbd_claim_s   claim_q;    // registered claim result
	mwbd_claim_s   claim_d;

	// dword decode of the config offset
	wire logic [7:0]  dw_off  = {cfg_req.offset[7:2], 2'b00};
	wire logic        cfg_wr  = cfg_req.valid & cfg_req.write;
	wire logic        cfg_rd  = cfg_req.valid & ~cfg_req.write;
	wire logic        sel_elo = (dw_off == MWBD_OFF_EGR_LO);
	wire logic        sel_ehi = (dw_off == MWBD_OFF_EGR_HI);
	wire logic        sel_rlo = (dw_off == MWBD_OFF_REG_LO);
	wire logic        sel_rhi = (dw_off == MWBD_OFF_REG_HI);

	// byte enables expanded to a bit mask over one dword
	wire logic [31:0] be_bits = {{8{cfg_req.be[3]}}, {8{cfg_req.be[2]}},
	                             {8{cfg_req.be[1]}}, {8{cfg_req.be[0]}}};
	// lane mask placed over the low or high half of a 64-bit register
	wire logic [63:0] lo_mask = {32'h0000_0000, be_bits};
	wire logic [63:0] hi_mask = {be_bits, 32'h0000_0000};
	wire logic [63:0] wdat64  = {cfg_req.wdata, cfg_req.wdata};

	// write masks: only enabled lanes of the selected half, writable bits
	wire logic [63:0] egr_wm  = (cfg_wr & sel_elo) ? lo_mask & MWBD_EGR_WMASK
	                          : (cfg_wr & sel_ehi) ? hi_mask & MWBD_EGR_WMASK
	                          : 64'h0000_0000_0000_0000;
	wire logic [63:0] reg_wm  = (cfg_wr & sel_rlo) ? lo_mask & MWBD_REG_WMASK
	                          : (cfg_wr & sel_rhi) ? hi_mask & MWBD_REG_WMASK
	                          : 64'h0000_0000_0000_0000;

	// masked merge keeps reserved bits at zero whatever is written
	assign egr_d = (egr_q & ~egr_wm) | (wdat64 & egr_wm);
	assign reg_d = (reg_q & ~reg_wm) | (wdat64 & reg_wm);

	// status word: only the capability list bit is implemented here
	wire logic [31:0] stat_word = 32'h0000_0001 << MWBD_CAP_LIST_BIT;

	// read mux; unmapped offsets and the write path answer zero
	wire logic [31:0] rd_word =
		(dw_off == MWBD_OFF_STATUS) ? stat_word :
		(dw_off == MWBD_OFF_CAP_PTR) ? {24'h00_0000, MWBD_CAP_PTR_VAL} :
		sel_elo                     ? egr_q[31:0] :
		sel_ehi                     ? egr_q[63:32] :
		sel_rlo                     ? reg_q[31:0] :
		sel_rhi                     ? reg_q[63:32] :
		32'h0000_0000;

	// every request gets exactly one answer on the next edge
	assign rsp_d.valid = cfg_req.valid;
	assign rsp_d.rdata = cfg_rd ? rd_word : 32'h0000_0000;

	// window decoders; hits only claim, no storage lies behind them
	logic [13:0] egr_off_w;  // offset from egress decoder
	logic [13:0] reg_off_w;  // offset from register window decoder
	logic        egr_hit_w;
	logic        reg_hit_w;

	mwbd_win_dec #(
		.AMASK (MWBD_EGR_AMASK),
		.OMASK (MWBD_EGR_OMASK)
	) u_egr_dec (
		.valid  (mem_req.valid),
		.addr   (mem_req.addr),
		.base   (egr_q),
		.hit    (egr_hit_w),
		.offset (egr_off_w)
	);

	mwbd_win_dec #(
		.AMASK (MWBD_REG_AMASK),
		.OMASK (MWBD_REG_OMASK)
	) u_reg_dec (
		.valid  (mem_req.valid),
		.addr   (mem_req.addr),
		.base   (reg_q),
		.hit    (reg_hit_w),
		.offset (reg_off_w)
	);

	// offsets are forwarded only with a claim, so nothing leaks when idle
	assign claim_d.egr_hit = egr_hit_w;
	assign claim_d.egr_off = egr_hit_w ? egr_off_w[11:0] : 12'h000;
	assign claim_d.reg_hit = reg_hit_w;
	assign claim_d.reg_off = reg_hit_w ? reg_off_w : 14'h0000;

	// window registers: both windows start disabled at zero base
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			egr_q <= MWBD_WIN_RESET;
			reg_q <= MWBD_WIN_RESET;
		end else begin
			egr_q <= egr_d;
			reg_q <= reg_d;
		end
	end

	// answer and claim pipeline registers
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rsp_q   <= '0;
			claim_q <= '0;
		end else begin
			rsp_q   <= rsp_d;
			claim_q <= claim_d;
		end
	end

	assign cfg_rsp = rsp_q;
	assign claim   = claim_q;

	// firmware programs the bases; this block only honours what it gets
	// (a base above 64 GB is impossible to write, so no check is needed)

	// ---- checks ----
	// marks the first sampled edge after reset release
	logic seen_q;
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			seen_q <= 1'b0;
		end else begin
			seen_q <= 1'b1;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);

	a_cap_ptr_fixed: assert property (
		cfg_rd && dw_off == MWBD_OFF_CAP_PTR |=> cfg_rsp.valid
		&& cfg_rsp.rdata == {24'h00_0000, MWBD_CAP_PTR_VAL})
		else $error("capability pointer read wrong");

	a_egr_base_write: assert property (
		cfg_wr && sel_elo && cfg_req.be[3] |=>
		egr_q[31:24] == $past(cfg_req.wdata[31:24]))
		else $error("egress base byte not stored");

	a_egr_upper_zero: assert property (
		egr_q[63:36] == 28'h000_0000 && reg_q[63:36] == 28'h000_0000)
		else $error("reserved upper base bits set");

	a_win_reset_zero: assert property (
		!seen_q |-> egr_q == MWBD_WIN_RESET && reg_q == MWBD_WIN_RESET)
		else $error("window registers not zero after reset");

	a_egr_enable_wr: assert property (
		cfg_wr && sel_elo && cfg_req.be[0] |=>
		egr_q[0] == $past(cfg_req.wdata[0]))
		else $error("egress enable not written");

	// back to back writes are legal, so the hold check keys on no write
	a_egr_enable_hold: assert property (
		!(cfg_wr && sel_elo && cfg_req.be[0]) |=>
		egr_q[0] == $past(egr_q[0]))
		else $error("egress enable changed without a write");

	a_egr_no_claim: assert property (
		mem_req.valid && !egr_q[0] |=> !claim.egr_hit)
		else $error("disabled egress window claimed");

	a_egr_claim: assert property (
		mem_req.valid && egr_q[0] && mem_req.addr[63:36] == 28'h0
		&& mem_req.addr[35:12] == egr_q[35:12] |=> claim.egr_hit
		&& claim.egr_off == $past(mem_req.addr[11:0]))
		else $error("egress window access not claimed");

	a_reg_no_claim: assert property (
		mem_req.valid && !reg_q[0] |=> !claim.reg_hit)
		else $error("disabled register window claimed");

	a_reg_claim: assert property (
		mem_req.valid && reg_q[0] && mem_req.addr[63:36] == 28'h0
		&& mem_req.addr[35:14] == reg_q[35:14] |=> claim.reg_hit)
		else $error("register window access not claimed");

	a_status_capability_list_present: assert property (
		cfg_rd && dw_off == MWBD_OFF_STATUS |=> cfg_rsp.rdata[20])
		else $error("capability list bit not set");

	a_low_reserved: assert property (
		egr_q[11:1] == 11'h000 && reg_q[13:1] == 13'h0000)
		else $error("reserved low base bits set");

	c_egr_claim:  cover property (claim.egr_hit);
	c_reg_claim:  cover property (claim.reg_hit);
	c_reg_write:  cover property (cfg_wr && sel_rlo && cfg_req.be[0]);
	c_cap_read:   cover property (cfg_rd && dw_off == MWBD_OFF_CAP_PTR);
endmodule
`default_nettype wire

// file: hw/mwbd_pkg.sv
// Purpose: shared constants and carriers for the window base decode block
// Assumes: config offsets are byte addresses of dword-aligned registers
// Notes:   each 64-bit window register spans two config dwords
`default_nettype none
package mwbd_pkg;

	// config dword offsets (byte address, low two bits ignored)
	localparam logic [7:0]  MWBD_OFF_STATUS  = 8'h04;  // command/status
	localparam logic [7:0]  MWBD_OFF_CAP_PTR = 8'h34;  // capability ptr
	localparam logic [7:0]  MWBD_OFF_EGR_LO  = 8'h40;  // egress base low
	localparam logic [7:0]  MWBD_OFF_EGR_HI  = 8'h44;  // egress base high
	localparam logic [7:0]  MWBD_OFF_REG_LO  = 8'h48;  // reg window low
	localparam logic [7:0]  MWBD_OFF_REG_HI  = 8'h4C;  // reg window high

	// fixed read values
	localparam logic [7:0]  MWBD_CAP_PTR_VAL = 8'hE0;
	// capability list present is status bit 4, status sits at byte 6
	localparam int unsigned MWBD_CAP_LIST_BIT = 20;

	// writable bits of each window register: base field and enable bit 0
	localparam logic [63:0] MWBD_EGR_WMASK   = 64'h0000_000F_FFFF_F001;
	localparam logic [63:0] MWBD_REG_WMASK   = 64'h0000_000F_FFFF_C001;
	localparam logic [63:0] MWBD_WIN_RESET   = 64'h0000_0000_0000_0000;

	// address compare masks over bits 35:0, and offset masks in window
	localparam logic [35:0] MWBD_EGR_AMASK   = 36'hF_FFFF_F000;
	localparam logic [35:0] MWBD_REG_AMASK   = 36'hF_FFFF_C000;
	localparam logic [13:0] MWBD_EGR_OMASK   = 14'h0FFF;
	localparam logic [13:0] MWBD_REG_OMASK   = 14'h3FFF;

	// config cycle towards bus 0, device 0, function 0
	typedef struct packed {
		logic        valid;   // one-cycle request strobe
		logic        write;   // 1 write, 0 read
		logic [7:0]  offset;  // byte offset in config space
		logic [3:0]  be;      // byte enables
		logic [31:0] wdata;   // write data
	} mwbd_cfg_req_s;

	typedef struct packed {
		logic        valid;   // one cycle after each request
		logic [31:0] rdata;   // read data, zero for writes
	} mwbd_cfg_rsp_s;

	// memory access to be claimed or passed on
	typedef struct packed {
		logic        valid;
		logic [63:0] addr;
	} mwbd_mem_req_s;

	typedef struct packed {
		logic        egr_hit;  // egress window claims the access
		logic [11:0] egr_off;  // offset inside egress window
		logic        reg_hit;  // register window claims the access
		logic [13:0] reg_off;  // offset inside register window
	} mwbd_claim_s;

endpackage
`default_nettype wire

// file: hw/mwbd_win_dec.sv
// Purpose: address match for one naturally aligned base window
// Assumes: base register holds the base in 35:N and the enable in bit 0
// Notes:   combinational; the caller registers the result
`timescale 1ns/100ps
`default_nettype none
module mwbd_win_dec
	import mwbd_pkg::*;
#(
	parameter logic [35:0] AMASK = MWBD_EGR_AMASK,
	parameter logic [13:0] OMASK = MWBD_EGR_OMASK
) (
	input  wire logic        valid,
	input  wire logic [63:0] addr,
	input  wire logic [63:0] base,
	output logic             hit,
	output logic [13:0]      offset
);
	// accesses above 64 GB can never match, the base has no bits there
	wire logic low_space = (addr[63:36] == 28'h000_0000);
	// only the bits at and above the alignment boundary are compared
	wire logic base_eq   = (((addr[35:0] ^ base[35:0]) & AMASK) == 36'h0);

	// enable gates the claim; disabled windows claim nothing
	assign hit    = valid & base[0] & low_space & base_eq;
	assign offset = addr[13:0] & OMASK;
endmodule
`default_nettype wire

// file: dv/mwbd_top_tb.sv
// Purpose: self-checking bench for the window base decode block
// Assumes: config answer and memory claim both come one cycle later
// Notes:   inputs change and outputs are read on the falling edge
`timescale 1ns/100ps
`default_nettype none
module mwbd_top_tb
	import mwbd_pkg::*;
;
	logic          clk;      // 100 MHz bench clock
	logic          arst_n;   // async reset, active low
	mwbd_cfg_req_s cfg_req;  // config request towards the block
	mwbd_cfg_rsp_s cfg_rsp;  // config answer
	mwbd_mem_req_s mem_req;  // memory access to be claimed
	mwbd_claim_s   claim;    // claim result
	int            fails;    // mismatches seen
	int            checked;  // comparisons made

	mwbd_top dut_u (
		.clk     (clk),
		.arst_n  (arst_n),
		.cfg_req (cfg_req),
		.cfg_rsp (cfg_rsp),
		.mem_req (mem_req),
		.claim   (claim)
	);

	// free running clock, period 10 ns
	always #5 clk = ~clk;

	// one comparison; four-state equality so unknowns never match
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		checked++;
		if (got !== exp) begin
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
			fails++;
		end
	endtask

	// one config cycle; the answer is registered, so read it a cycle on
	task automatic cfg(input logic is_wr, input logic [7:0] off,
		input logic [3:0] be, input logic [31:0] wd, input logic [31:0] exp);
		@(negedge clk);
		cfg_req = '{1'b1, is_wr, off, be, wd};
		@(negedge clk);
		cfg_req.valid = 1'b0;
		chk({63'h0, cfg_rsp.valid}, 64'h1);
		chk({32'h0, cfg_rsp.rdata}, {32'h0, exp});
	endtask

	// write answers carry zero data
	task automatic wr(input logic [7:0] off, input logic [3:0] be,
		input logic [31:0] wd);
		cfg(1'b1, off, be, wd, 32'h0);
	endtask

	// full dword read
	task automatic rd(input logic [7:0] off, input logic [31:0] exp);
		cfg(1'b0, off, 4'hF, 32'h0, exp);
	endtask

	// one memory access; claim fields packed as in the carrier struct
	task automatic mem(input logic [63:0] a, input logic [27:0] exp);
		@(negedge clk);
		mem_req = '{1'b1, a};
		@(negedge clk);
		mem_req.valid = 1'b0;
		chk({36'h0, claim}, {36'h0, exp});
	endtask

	// reset pulse of the given length in cycles
	task automatic pulse_reset(input int cycles);
		@(negedge clk);
		arst_n = 1'b0;
		repeat (cycles) @(negedge clk);
		arst_n = 1'b1;
	endtask

	// single place where the run ends
	task automatic finish_test;
		$display("checks %0d mismatches %0d", checked, fails);
		if (fails == 0 && checked > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	// watchdog: far beyond the roughly 80 cycles the sequence needs
	initial begin
		#200000;
		fails++;
		finish_test();
	end

	// main sequence
	initial begin
		clk     = 1'b0;
		arst_n  = 1'b0;
		cfg_req = '0;
		mem_req = '0;
		fails   = 0;
		checked = 0;
		repeat (4) @(negedge clk);
		arst_n = 1'b1;
		// fixed pointer, not writable
		rd(8'h34, 32'h0000_00E0);
		wr(8'h34, 4'hF, 32'hFFFF_FFFF);
		rd(8'h34, 32'h0000_00E0);
		rd(8'h04, 32'h0010_0000);
		// both windows cleared and disabled out of reset
		rd(8'h40, 32'h0);
		rd(8'h44, 32'h0);
		rd(8'h48, 32'h0);
		rd(8'h4C, 32'h0);
		rd(8'h50, 32'h0);
		mem(64'h0, 28'h0);
		// a programmed base alone must not claim anything
		wr(8'h40, 4'hF, 32'h0001_2000);
		mem(64'h0000_0000_0001_2010, 28'h0);
		// writable field and reserved bits of the egress register
		wr(8'h40, 4'hF, 32'hFFFF_FFFF);
		rd(8'h40, 32'hFFFF_F001);
		wr(8'h44, 4'hF, 32'hFFFF_FFFF);
		rd(8'h44, 32'h0000_000F);
		// enabled egress window at 5_0001_2000
		wr(8'h40, 4'hF, 32'h0001_2001);
		wr(8'h44, 4'hF, 32'h0000_0005);
		mem(64'h0000_0005_0001_2ABC, {1'b1, 12'hABC, 15'h0});
		mem(64'h0000_0005_0001_2FFF, {1'b1, 12'hFFF, 15'h0});
		mem(64'h0000_0005_0001_3000, 28'h0);
		mem(64'h0000_0015_0001_2ABC, 28'h0);
		// writable field of the register window
		wr(8'h48, 4'hF, 32'hFFFF_FFFF);
		rd(8'h48, 32'hFFFF_C001);
		// enabled register window at C000
		wr(8'h48, 4'hF, 32'h0000_C001);
		wr(8'h4C, 4'hF, 32'h0);
		mem(64'h0000_0000_0000_C123, {13'h0, 1'b1, 14'h0123});
		mem(64'h0000_0000_0000_FFFF, {13'h0, 1'b1, 14'h3FFF});
		mem(64'h0000_0000_0001_0000, 28'h0);
		mem(64'h0000_0000_0000_BFFF, 28'h0);
		// clearing the enable through lane 0 only keeps the base
		wr(8'h48, 4'h1, 32'h0);
		rd(8'h48, 32'h0000_C000);
		mem(64'h0000_0000_0000_C123, 28'h0);
		// a second reset in mid-run clears both windows again
		pulse_reset(2);
		rd(8'h40, 32'h0);
		rd(8'h44, 32'h0);
		rd(8'h48, 32'h0);
		mem(64'h0000_0005_0001_2ABC, 28'h0);
		finish_test();
	end
endmodule
`default_nettype wire
